// [design/ccc_core_regs.sv]
// core configuration, system control and branch unit control registers
`timescale 1ns/1ns
`default_nettype none
`include "ccc_defs.svh"
module ccc_core_regs
  import ccc_pkg::*;
#(
  parameter int BTB_DEPTH = `CCC_BTB_DEPTH,
  parameter int BTB_IW    = $clog2(BTB_DEPTH)
) (
  input  wire logic              REF_CLK,
  input  wire logic              RST_N,
  input  wire ccc_spr_req_s      SPR_REQ,
  output logic [31:0]            SPR_RDATA,
  output logic                   SPR_ILLEGAL,
  input  wire logic              FIS_EVENT,
  input  wire logic              MCHK_PIN_N,
  output logic                   MCHK_REPORT,
  input  wire logic              WAIT_ENABLE,
  output logic                   DOZE_MODE,
  output logic                   NAP_MODE,
  output logic                   SLEEP_MODE,
  input  wire ccc_irq_s          IRQ_TAKEN,
  input  wire logic              RSV_SET,
  input  wire logic              RSV_CLR,
  output logic                   RESERVATION,
  output logic                   DBG_CLR_EXT_EN,
  output logic                   DBG_CLR_CRIT_EN,
  output logic                   CLR_DBG_EN,
  output logic                   DBG_USE_DBG_PAIR,
  input  wire logic              DBG_RETURN_EXEC,
  output logic                   DBG_RETURN_ILLEGAL,
  output logic                   TOUCH_NOOP,
  input  wire logic              TB_EXT_CLK,
  output logic [63:0]            TIMEBASE,
  output logic [7:0]             SYSTEM_CTRL_OUT,
  input  wire logic              BR_VALID,
  input  wire logic              BR_DISP_MSB,
  input  wire logic [BTB_IW-1:0] BR_IDX,
  output logic                   BR_HIT,
  output logic                   BR_ALLOC,
  output logic                   BR_PRED_TAKEN
);
  typedef struct packed {
    logic [31:0] timer_status;
    logic [31:0] hw;
    logic [7:0]  sysctl;
    logic        rsv;
    logic [31:0] br;
    logic [31:0] rdata;
    logic        illegal;
    logic        mchk;
    logic [2:0]  pmode;
    logic [2:0]  clr;
    logic        dbg_pair;
    logic        dbg_ret_ill;
    logic        noop;
    logic        tb_ext_q;
    logic [63:0] tb;
    logic        hit;
    logic        alloc;
    logic        pred;
  } ccc_st_s;
  ccc_st_s st_ff, nxt_st;
  logic       flash;
  logic       look_valid;
  logic       dbg_on;
  logic       clr_en;
  logic       tb_tick;
  logic       bwd;
  logic       rsv_kill;
  ccc_alloc_e apol;
  assign dbg_on = st_ff.hw[`CCC_HW_DBG_UNIT];
  assign bwd    = BR_DISP_MSB;
  assign apol   = ccc_alloc_e'(st_ff.br[`CCC_BR_ALLOC_HI:`CCC_BR_ALLOC_LO]);
  assign flash  = SPR_REQ.wr && SPR_REQ.spr == `CCC_SPR_BRANCH && SPR_REQ.wdata[`CCC_BR_FLASH];
  assign clr_en = st_ff.hw[`CCC_HW_ICR];
  assign rsv_kill = clr_en && (IRQ_TAKEN.ext_irq || IRQ_TAKEN.crit_irq || IRQ_TAKEN.nmi_irq);
  // external clock sampled as a synchronous level; a rising edge is one tick
  assign tb_tick = st_ff.hw[`CCC_HW_TBSEL] ? (st_ff.tb_ext_q == 1'b0 && TB_EXT_CLK) : 1'b1;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.illegal = 1'b0;
    // writes: timer status is clear-only, never loaded
    if (SPR_REQ.wr) begin
      if (SPR_REQ.spr == `CCC_SPR_TMRSTS) begin
        nxt_st.timer_status = st_ff.timer_status & ~SPR_REQ.wdata & `CCC_TMRSTS_MASK;
      end else if (SPR_REQ.spr == `CCC_SPR_HWCFG) begin
        nxt_st.hw = SPR_REQ.wdata & `CCC_HWCFG_MASK;
      end else if (SPR_REQ.spr == `CCC_SPR_SYSCTL) begin
        nxt_st.sysctl = SPR_REQ.wdata[`CCC_SYS_CTL_HI:`CCC_SYS_CTL_LO];
      end else if (SPR_REQ.spr == `CCC_SPR_BRANCH) begin
        nxt_st.br = SPR_REQ.wdata & `CCC_BRANCH_MASK;
      end else begin
        nxt_st.illegal = 1'b1;
      end
    end
    // event set wins over a same-cycle clear
    if (FIS_EVENT) begin
      nxt_st.timer_status[`CCC_TMRSTS_FIS] = 1'b1;
    end
    nxt_st.rdata = '0;
    if (SPR_REQ.rd) begin
      if (SPR_REQ.spr == `CCC_SPR_TMRSTS) begin
        nxt_st.rdata = st_ff.timer_status;
      end else if (SPR_REQ.spr == `CCC_SPR_HWCFG) begin
        nxt_st.rdata = st_ff.hw;
      end else if (SPR_REQ.spr == `CCC_SPR_SYSCTL) begin
        nxt_st.rdata[`CCC_SYS_CTL_HI:`CCC_SYS_CTL_LO] = st_ff.sysctl;
        nxt_st.rdata[`CCC_SYS_RSV] = st_ff.rsv;
      end else if (SPR_REQ.spr == `CCC_SPR_BRANCH) begin
        nxt_st.rdata = st_ff.br;
      end else begin
        nxt_st.illegal = 1'b1;
      end
    end
    // reservation: interrupt clear beats a same-cycle set
    if (RSV_SET) begin
      nxt_st.rsv = 1'b1;
    end
    if (RSV_CLR || rsv_kill) begin
      nxt_st.rsv = 1'b0;
    end
    nxt_st.mchk = !MCHK_PIN_N && st_ff.hw[`CCC_HW_MCHK_EN];
    nxt_st.pmode = {3{WAIT_ENABLE}} &
                   {st_ff.hw[`CCC_HW_DOZE], st_ff.hw[`CCC_HW_NAP], st_ff.hw[`CCC_HW_SLEEP]};
    // debug unit off forces every clearing control to one
    nxt_st.clr[2] = IRQ_TAKEN.dbg_irq && (!dbg_on || st_ff.hw[`CCC_HW_DCLR_EXT]);
    nxt_st.clr[1] = IRQ_TAKEN.dbg_irq && (!dbg_on || st_ff.hw[`CCC_HW_DCLR_CRIT]);
    // critical, watchdog and machine check sources merged before the flop so the output is a plain register
    nxt_st.clr[0] = ((IRQ_TAKEN.crit_irq || IRQ_TAKEN.wdog_irq) && (!dbg_on || st_ff.hw[`CCC_HW_CCLR_DBG])) ||
                    (IRQ_TAKEN.mchk_irq && (!dbg_on || st_ff.hw[`CCC_HW_MCLR_DBG]));
    nxt_st.dbg_pair    = dbg_on;
    nxt_st.dbg_ret_ill = DBG_RETURN_EXEC && !dbg_on;
    nxt_st.noop        = st_ff.hw[`CCC_HW_TOUCH_NOP];
    nxt_st.tb_ext_q    = TB_EXT_CLK;
    if (st_ff.hw[`CCC_HW_TIMEBASE_ENABLE] && tb_tick) begin
      nxt_st.tb = st_ff.tb + 64'h1;
    end
    // branch unit: buffer only used while prediction enabled
    nxt_st.hit   = BR_VALID && st_ff.br[`CCC_BR_EN] && look_valid;
    nxt_st.alloc = 1'b0;
    nxt_st.pred  = 1'b0;
    if (BR_VALID && !(st_ff.br[`CCC_BR_EN] && look_valid)) begin
      case (st_ff.br[`CCC_BR_PRED_HI:`CCC_BR_PRED_LO])
        2'h0: nxt_st.pred = 1'b1;
        2'h1: nxt_st.pred = !bwd;
        2'h2: nxt_st.pred = bwd;
        default: nxt_st.pred = 1'b0;
      endcase
      if (st_ff.br[`CCC_BR_EN]) begin
        case (apol)
          CCC_ALLOC_ALL:  nxt_st.alloc = 1'b1;
          CCC_ALLOC_NBWD: nxt_st.alloc = !bwd;
          CCC_ALLOC_NFWD: nxt_st.alloc = bwd;
          default:        nxt_st.alloc = 1'b0;
        endcase
      end
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      st_ff       <= '0;
      st_ff.hw    <= `CCC_HWCFG_RESET;
      st_ff.br    <= `CCC_BRANCH_RESET;
      st_ff.sysctl <= 8'h00;
    end else begin
      st_ff <= nxt_st;
    end
  end
  ccc_btb_valid #(
    .DEPTH (BTB_DEPTH),
    .IW    (BTB_IW)
  ) u_btb (
    .clk        (REF_CLK),
    .rst_n      (RST_N),
    .flash      (flash),
    .alloc      (nxt_st.alloc),
    .alloc_idx  (BR_IDX),
    .look_idx   (BR_IDX),
    .look_valid (look_valid)
  );
  assign SPR_RDATA          = st_ff.rdata;
  assign SPR_ILLEGAL        = st_ff.illegal;
  assign MCHK_REPORT        = st_ff.mchk;
  assign DOZE_MODE          = st_ff.pmode[2];
  assign NAP_MODE           = st_ff.pmode[1];
  assign SLEEP_MODE         = st_ff.pmode[0];
  assign RESERVATION        = st_ff.rsv;
  assign DBG_CLR_EXT_EN     = st_ff.clr[2];
  assign DBG_CLR_CRIT_EN    = st_ff.clr[1];
  assign CLR_DBG_EN         = st_ff.clr[0];
  assign DBG_USE_DBG_PAIR   = st_ff.dbg_pair;
  assign DBG_RETURN_ILLEGAL = st_ff.dbg_ret_ill;
  assign TOUCH_NOOP         = st_ff.noop;
  assign TIMEBASE           = st_ff.tb;
  assign SYSTEM_CTRL_OUT    = st_ff.sysctl;
  assign BR_HIT             = st_ff.hit;
  assign BR_ALLOC           = st_ff.alloc;
  assign BR_PRED_TAKEN      = st_ff.pred;
  property p_tsr_w1c;
    @(posedge REF_CLK) disable iff (!RST_N)
    SPR_REQ.wr && SPR_REQ.spr == `CCC_SPR_TMRSTS && SPR_REQ.wdata[`CCC_TMRSTS_FIS] && !FIS_EVENT
    |=> !st_ff.timer_status[`CCC_TMRSTS_FIS];
  endproperty
  a_tsr_w1c: assert property (p_tsr_w1c) else $error("timer status bit not cleared");
  property p_fis_set;
    @(posedge REF_CLK) disable iff (!RST_N) FIS_EVENT |=> st_ff.timer_status[`CCC_TMRSTS_FIS];
  endproperty
  a_fis_set: assert property (p_fis_set) else $error("fixed interval status not set");
  property p_tsr_rsvd;
    @(posedge REF_CLK) disable iff (!RST_N) (st_ff.timer_status & ~`CCC_TMRSTS_MASK) == 32'h0000_0000;
  endproperty
  a_tsr_rsvd: assert property (p_tsr_rsvd) else $error("unimplemented timer status bit set");
  property p_mchk;
    @(posedge REF_CLK) disable iff (!RST_N)
    MCHK_REPORT |-> $past(st_ff.hw[`CCC_HW_MCHK_EN]) && !$past(MCHK_PIN_N);
  endproperty
  a_mchk: assert property (p_mchk) else $error("masked machine check reported");
  property p_mchk_mask;
    @(posedge REF_CLK) disable iff (!RST_N) !st_ff.hw[`CCC_HW_MCHK_EN] |=> !MCHK_REPORT;
  endproperty
  a_mchk_mask: assert property (p_mchk_mask) else $error("machine check reported while masked");
  property p_doze;
    @(posedge REF_CLK) disable iff (!RST_N) WAIT_ENABLE && st_ff.hw[`CCC_HW_DOZE] |=> DOZE_MODE;
  endproperty
  a_doze: assert property (p_doze) else $error("doze not entered");
  property p_nap;
    @(posedge REF_CLK) disable iff (!RST_N) WAIT_ENABLE && st_ff.hw[`CCC_HW_NAP] |=> NAP_MODE;
  endproperty
  a_nap: assert property (p_nap) else $error("nap not entered");
  property p_sleep;
    @(posedge REF_CLK) disable iff (!RST_N) WAIT_ENABLE && st_ff.hw[`CCC_HW_SLEEP] |=> SLEEP_MODE;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
  property p_rsv;
    @(posedge REF_CLK) disable iff (!RST_N) rsv_kill |=> !RESERVATION;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reservation survived interrupt");
  property p_rsv_keep;
    @(posedge REF_CLK) disable iff (!RST_N) RESERVATION && !clr_en && !RSV_CLR |=> RESERVATION;
  endproperty
  a_rsv_keep: assert property (p_rsv_keep) else $error("reservation lost with clearing off");
  property p_nhr_keep;
    @(posedge REF_CLK) disable iff (!RST_N)
    st_ff.hw[`CCC_HW_NHR] && !(SPR_REQ.wr && SPR_REQ.spr == `CCC_SPR_HWCFG) |=> st_ff.hw[`CCC_HW_NHR];
  endproperty
  a_nhr_keep: assert property (p_nhr_keep) else $error("not-reset flag dropped without reset");
  property p_tb_hold;
    @(posedge REF_CLK) disable iff (!RST_N) !st_ff.hw[`CCC_HW_TIMEBASE_ENABLE] |=> $stable(TIMEBASE);
  endproperty
  a_tb_hold: assert property (p_tb_hold) else $error("time base moved while disabled");
  property p_dbg_off;
    @(posedge REF_CLK) disable iff (!RST_N) !dbg_on && IRQ_TAKEN.dbg_irq |=> DBG_CLR_EXT_EN && DBG_CLR_CRIT_EN;
  endproperty
  a_dbg_off: assert property (p_dbg_off) else $error("enables not cleared with debug unit off");
  property p_rfdi;
    @(posedge REF_CLK) disable iff (!RST_N) DBG_RETURN_EXEC && dbg_on |=> !DBG_RETURN_ILLEGAL;
  endproperty
  a_rfdi: assert property (p_rfdi) else $error("debug return flagged illegal");
  property p_rfdi_ill;
    @(posedge REF_CLK) disable iff (!RST_N) DBG_RETURN_EXEC && !dbg_on |=> DBG_RETURN_ILLEGAL;
  endproperty
  a_rfdi_ill: assert property (p_rfdi_ill) else $error("debug return accepted with unit off");
  property p_sysout;
    @(posedge REF_CLK) disable iff (!RST_N) SPR_REQ.wr && SPR_REQ.spr == `CCC_SPR_SYSCTL
    |=> SYSTEM_CTRL_OUT == $past(SPR_REQ.wdata[`CCC_SYS_CTL_HI:`CCC_SYS_CTL_LO]);
  endproperty
  a_sysout: assert property (p_sysout) else $error("system control outputs not updated");
  property p_nohit;
    @(posedge REF_CLK) disable iff (!RST_N) !st_ff.br[`CCC_BR_EN] |=> !BR_HIT && !BR_ALLOC;
  endproperty
  a_nohit: assert property (p_nohit) else $error("hit or allocation while disabled");
  property p_alloc_none;
    @(posedge REF_CLK) disable iff (!RST_N) BR_VALID && apol == CCC_ALLOC_NONE |=> !BR_ALLOC;
  endproperty
  a_alloc_none: assert property (p_alloc_none) else $error("allocation under code 11");
  property p_static_predict_sel_none;
    @(posedge REF_CLK) disable iff (!RST_N) st_ff.br[`CCC_BR_PRED_HI:`CCC_BR_PRED_LO] == 2'h3 |=> !BR_PRED_TAKEN;
  endproperty
  a_static_predict_sel_none: assert property (p_static_predict_sel_none) else $error("predicted taken under code 11");
  property p_pred_all;
    @(posedge REF_CLK) disable iff (!RST_N)
    BR_VALID && !look_valid && st_ff.br[`CCC_BR_PRED_HI:`CCC_BR_PRED_LO] == 2'h0 |=> BR_PRED_TAKEN;
  endproperty
  a_pred_all: assert property (p_pred_all) else $error("miss not predicted taken under code 00");
  property p_flash_rd;
    @(posedge REF_CLK) disable iff (!RST_N) SPR_REQ.rd && SPR_REQ.spr == `CCC_SPR_BRANCH |=> !SPR_RDATA[`CCC_BR_FLASH];
  endproperty
  a_flash_rd: assert property (p_flash_rd) else $error("flash bit read as one");
  c_flash: cover property (@(posedge REF_CLK) flash);
  c_alloc: cover property (@(posedge REF_CLK) BR_ALLOC);
  c_sleep: cover property (@(posedge REF_CLK) SLEEP_MODE);
endmodule
`default_nettype wire

// [design/ccc_defs.svh]
// constants for the core configuration and control register bank
`ifndef CCC_DEFS_SVH
`define CCC_DEFS_SVH
`define CCC_SPR_HWCFG      10'h3F0
`define CCC_SPR_SYSCTL     10'h3F1
`define CCC_SPR_BRANCH     10'h3F5
`define CCC_SPR_TMRSTS     10'h150
`define CCC_HWCFG_RESET    32'h0000_0000
`define CCC_SYSCTL_RESET   32'h0000_0000
`define CCC_BRANCH_RESET   32'h0000_0000
`define CCC_TMRSTS_MASK    32'hFC00_0000
`define CCC_TMRSTS_FIS     26
`define CCC_HW_MCHK_EN     31
`define CCC_HW_DOZE        23
`define CCC_HW_NAP         22
`define CCC_HW_SLEEP       21
`define CCC_HW_ICR         17
`define CCC_HW_NHR         16
`define CCC_HW_TIMEBASE_ENABLE        14
`define CCC_HW_TBSEL       13
`define CCC_HW_DCLR_EXT    12
`define CCC_HW_DCLR_CRIT   11
`define CCC_HW_CCLR_DBG    10
`define CCC_HW_MCLR_DBG    9
`define CCC_HW_DBG_UNIT    8
`define CCC_HW_TOUCH_NOP   0
`define CCC_HWCFG_MASK     32'h80E3_7F01
`define CCC_SYS_CTL_HI     15
`define CCC_SYS_CTL_LO     8
`define CCC_SYS_RSV        7
`define CCC_BR_FLASH       9
`define CCC_BR_ALLOC_HI    5
`define CCC_BR_ALLOC_LO    4
`define CCC_BR_PRED_HI     2
`define CCC_BR_PRED_LO     1
`define CCC_BR_EN          0
`define CCC_BRANCH_MASK    32'h0000_0037
`define CCC_BTB_DEPTH      16
`endif

// [design/ccc_pkg.sv]
// types for the core configuration and control register bank
package ccc_pkg;
  typedef enum logic [1:0] {
    CCC_ALLOC_ALL  = 2'h0,
    CCC_ALLOC_NBWD = 2'h1,
    CCC_ALLOC_NFWD = 2'h2,
    CCC_ALLOC_NONE = 2'h3
  } ccc_alloc_e;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [9:0]  spr;
    logic [31:0] wdata;
  } ccc_spr_req_s;
  typedef struct packed {
    logic        ext_irq;
    logic        crit_irq;
    logic        wdog_irq;
    logic        nmi_irq;
    logic        mchk_irq;
    logic        dbg_irq;
  } ccc_irq_s;
endpackage

// [design/ccc_btb_valid.sv]
// valid flags of the branch target buffer, with flash clear and lookup
`timescale 1ns/1ns
`default_nettype none
module ccc_btb_valid
  import ccc_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int IW    = $clog2(DEPTH)
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          flash,
  input  wire logic          alloc,
  input  wire logic [IW-1:0] alloc_idx,
  input  wire logic [IW-1:0] look_idx,
  output logic               look_valid
);
  typedef struct packed {
    logic [DEPTH-1:0] vld;
  } ccc_btbv_s;
  ccc_btbv_s st_ff, nxt_st;
  always_comb begin
    nxt_st = st_ff;
    if (alloc) begin
      nxt_st.vld[alloc_idx] = 1'b1;
    end
    // flash clear overrides a same-cycle allocation
    if (flash) begin
      nxt_st.vld = '0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign look_valid = st_ff.vld[look_idx];
  property p_flash_clears;
    @(posedge clk) disable iff (!rst_n) flash |=> st_ff.vld == '0;
  endproperty
  a_flash_clears: assert property (p_flash_clears) else $error("flash clear failed");
endmodule
`default_nettype wire

// [verif/test_ccc_core_regs.sv]
// self-checking bench for the core configuration and control registers
`timescale 1ns/1ns
`default_nettype none
`include "ccc_defs.svh"
module test_ccc_core_regs
  import ccc_pkg::*;
;
  logic         clk, rst_n, fixed_interval_status, mpin_n, wait_en, rsv_set, rsv_clr, dret, tbclk, bval, bbwd;
  logic         ill, mrep, doze, nap, sleep, rsv, clr_ee, clr_ce, clr_de, dpair, dret_ill, tnop;
  logic         hit, alloc, ptaken;
  logic [3:0]   bidx;
  logic [7:0]   sysout;
  logic [31:0]  rdata;
  logic [31:0]  seed = 32'h26;
  logic [63:0]  tb;
  ccc_spr_req_s req;
  ccc_irq_s     irq_in;
  int           err_count, check_count;

  ccc_core_regs i_ccc_core_regs (
    .REF_CLK(clk), .RST_N(rst_n), .SPR_REQ(req), .SPR_RDATA(rdata), .SPR_ILLEGAL(ill),
    .FIS_EVENT(fixed_interval_status), .MCHK_PIN_N(mpin_n), .MCHK_REPORT(mrep), .WAIT_ENABLE(wait_en),
    .DOZE_MODE(doze), .NAP_MODE(nap), .SLEEP_MODE(sleep), .IRQ_TAKEN(irq_in), .RSV_SET(rsv_set),
    .RSV_CLR(rsv_clr), .RESERVATION(rsv), .DBG_CLR_EXT_EN(clr_ee), .DBG_CLR_CRIT_EN(clr_ce),
    .CLR_DBG_EN(clr_de), .DBG_USE_DBG_PAIR(dpair), .DBG_RETURN_EXEC(dret),
    .DBG_RETURN_ILLEGAL(dret_ill), .TOUCH_NOOP(tnop), .TB_EXT_CLK(tbclk), .TIMEBASE(tb),
    .SYSTEM_CTRL_OUT(sysout), .BR_VALID(bval), .BR_DISP_MSB(bbwd), .BR_IDX(bidx), .BR_HIT(hit),
    .BR_ALLOC(alloc), .BR_PRED_TAKEN(ptaken)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // one table serves both allocation policy and static prediction
  function automatic logic dir_ok(logic [1:0] s, logic bwd);
    return (s == 2'h0) || (s == 2'h1 && !bwd) || (s == 2'h2 && bwd);
  endfunction

  function automatic logic [31:0] bw(logic f, logic [1:0] al, logic [1:0] pr, logic en);
    return {22'h0, f, 3'h0, al, 1'b0, pr, en};
  endfunction

  task automatic stop_test();
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(string n, logic [63:0] seen, logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wr(logic [9:0] a, logic [31:0] d);
    @(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, spr: a, wdata: d};
    @(posedge clk) req <= '0;
  endtask

  task automatic rchk(string n, logic [9:0] a, logic [31:0] e);
    @(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, spr: a, wdata: 32'h0};
    @(posedge clk) req <= '0;
    #1 chk(n, rdata, e);
  endtask

  task automatic pulse_irq(logic [5:0] q);
    @(posedge clk) irq_in <= q;
    @(posedge clk) irq_in <= '0;
    #1;
  endtask

  // outputs are one-cycle pulses, so they are looked at right after the taking edge
  task automatic dchk(logic [31:0] h, logic [5:0] q, logic [2:0] e);
    wr(`CCC_SPR_HWCFG, h);
    pulse_irq(q);
    chk("dbg clears", {clr_ee, clr_ce, clr_de}, e);
  endtask

  task automatic br(logic b, logic [3:0] ix);
    @(posedge clk) begin
      bval <= 1'b1;
      bbwd <= b;
      bidx <= ix;
    end
    @(posedge clk) bval <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    err_count++;
    stop_test();
  end

  initial begin
    logic [31:0] v, d;
    logic [63:0] t0;
    logic [1:0]  pr, al;
    logic        b, e;
    logic [5:0]  ql [3];
    ql = '{6'h20, 6'h10, 6'h04};
    {rst_n, fixed_interval_status, wait_en, rsv_set, rsv_clr, dret, tbclk, bval, bbwd} = '0;
    mpin_n = 1'b1;
    bidx = '0;
    req = '0;
    irq_in = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rchk("hwcfg rst", `CCC_SPR_HWCFG, 32'h0);
    rchk("sysctl rst", `CCC_SPR_SYSCTL, 32'h0);
    rchk("branch rst", `CCC_SPR_BRANCH, 32'h0);
    for (int i = 0; i < 4; i++) begin
      // clock select and power modes kept out: they must not change at random
      d = rnd() & 32'hFF1F_DFFF;
      wr(`CCC_SPR_HWCFG, d);
      rchk("hwcfg", `CCC_SPR_HWCFG, d & 32'h80E3_7F01);
      v = rnd();
      wr(`CCC_SPR_SYSCTL, v);
      rchk("sysctl", `CCC_SPR_SYSCTL, v & 32'h0000_FF00);
      chk("sysout", sysout, v[15:8]);
      wr(`CCC_SPR_TMRSTS, rnd());
      rchk("tsr", `CCC_SPR_TMRSTS, 32'h0);
    end
    wr(10'h3F2, 32'h1);
    #1 chk("illegal", ill, 1'b1);
    @(posedge clk) fixed_interval_status <= 1'b1;
    @(posedge clk) fixed_interval_status <= 1'b0;
    wr(`CCC_SPR_TMRSTS, 32'hFBFF_FFFF);
    rchk("tsr set", `CCC_SPR_TMRSTS, 32'h0400_0000);
    wr(`CCC_SPR_TMRSTS, 32'h0400_0000);
    rchk("tsr clr", `CCC_SPR_TMRSTS, 32'h0);
    mpin_n <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      wr(`CCC_SPR_HWCFG, {i[0], 31'h0});
      repeat (2) @(posedge clk);
      #1 chk("mchk", mrep, i[0]);
    end
    @(posedge clk) mpin_n <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(`CCC_SPR_HWCFG, 32'h0080_0000 >> i);
      repeat (2) @(posedge clk);
      #1 chk("no wait", {doze, nap, sleep}, 3'h0);
      @(posedge clk) wait_en <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("lowpwr", {doze, nap, sleep}, 3'h4 >> i);
      @(posedge clk) wait_en <= 1'b0;
      repeat (2) @(posedge clk);
    end
    wr(`CCC_SPR_HWCFG, 32'h0);
    for (int i = 0; i < 6; i++) begin
      if (i == 3)
        wr(`CCC_SPR_HWCFG, 32'h0002_0000);
      @(posedge clk) rsv_set <= 1'b1;
      @(posedge clk) rsv_set <= 1'b0;
      pulse_irq(ql[i % 3]);
      @(posedge clk);
      #1 chk("rsv", rsv, i < 3);
    end
    @(posedge clk) rsv_set <= 1'b1;
    @(posedge clk) rsv_set <= 1'b0;
    rchk("ats", `CCC_SPR_SYSCTL, {16'h0, v[15:8], 8'h80});
    @(posedge clk) rsv_clr <= 1'b1;
    @(posedge clk) rsv_clr <= 1'b0;
    rchk("ats clr", `CCC_SPR_SYSCTL, {16'h0, v[15:8], 8'h00});
    dchk(32'h0, 6'h01, 3'h6);
    dchk(32'h0, 6'h10, 3'h1);
    dchk(32'h0, 6'h02, 3'h1);
    dchk(32'h100, 6'h01, 3'h0);
    dchk(32'h1900, 6'h01, 3'h6);
    dchk(32'h1100, 6'h01, 3'h4);
    dchk(32'h500, 6'h10, 3'h1);
    dchk(32'h500, 6'h08, 3'h1);
    dchk(32'h500, 6'h02, 3'h0);
    dchk(32'h300, 6'h02, 3'h1);
    dchk(32'h300, 6'h10, 3'h0);
    for (int i = 0; i < 2; i++) begin
      wr(`CCC_SPR_HWCFG, i ? 32'h1 : 32'h100);
      @(posedge clk) dret <= 1'b1;
      @(posedge clk) dret <= 1'b0;
      #1 chk("dbg unit", {dpair, dret_ill, tnop}, i ? 3'h3 : 3'h4);
    end
    wr(`CCC_SPR_HWCFG, 32'h0001_0000);
    rchk("nhr", `CCC_SPR_HWCFG, 32'h0001_0000);
    @(posedge clk) rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rchk("nhr rst", `CCC_SPR_HWCFG, 32'h0);
    wr(`CCC_SPR_HWCFG, 32'h0000_4000);
    @(posedge clk);
    #1 t0 = tb;
    repeat (20) @(posedge clk);
    #1 chk("tb run", tb - t0, 64'h14);
    wr(`CCC_SPR_HWCFG, 32'h0);
    @(posedge clk);
    #1 t0 = tb;
    repeat (10) @(posedge clk);
    #1 chk("tb hold", tb, t0);
    // source is switched while stopped, then enabled, to avoid a counter glitch
    wr(`CCC_SPR_HWCFG, 32'h0000_2000);
    wr(`CCC_SPR_HWCFG, 32'h0000_6000);
    @(posedge clk);
    #1 t0 = tb;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk) tbclk <= ~tbclk;
    end
    repeat (3) @(posedge clk);
    #1 chk("tb ext", tb - t0, 64'h5);
    wr(`CCC_SPR_HWCFG, 32'h0000_2000);
    for (int j = 0; j < 8; j++) begin
      v = rnd();
      pr = j[1:0];
      al = v[5:4];
      b = v[0];
      wr(`CCC_SPR_BRANCH, bw(1'b1, al, pr, 1'b1));
      rchk("branch reg", `CCC_SPR_BRANCH, bw(1'b0, al, pr, 1'b1));
      br(b, v[11:8]);
      chk("miss", {hit, alloc, ptaken}, {1'b0, dir_ok(al, b), dir_ok(pr, b)});
      e = dir_ok(al, b);
      br(b, v[11:8]);
      chk("second", {hit, alloc}, {e, 1'b0});
      wr(`CCC_SPR_BRANCH, bw(1'b0, al, pr, 1'b0));
      br(b, v[11:8]);
      chk("disabled", {hit, alloc, ptaken}, {2'h0, dir_ok(pr, b)});
      wr(`CCC_SPR_BRANCH, bw(1'b0, al, pr, 1'b1));
      br(b, v[11:8]);
      chk("kept", hit, e);
      wr(`CCC_SPR_BRANCH, bw(1'b1, al, pr, 1'b0));
      wr(`CCC_SPR_BRANCH, bw(1'b0, 2'h3, pr, 1'b1));
      br(b, v[11:8]);
      chk("flushed", hit, 1'b0);
    end
    stop_test();
  end
endmodule
`default_nettype wire
